// [rtl/cebi_top.sv]
// External bus interface: AHB-Lite register port on one side, the
// asynchronous strobe/acknowledge processor bus on the other.
// Assumes bus pins are synchronous to hclk; the board resolves tristates.
`timescale 1ns/1ps
`default_nettype none
module cebi_top
  import cebi_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Address bus and space codes
  output logic [cebi_pkg::ADDR_W-1:0] addr_bus,
  output logic addr_bus_oe,
  output logic space_code_bit2,
  output logic space_code_bit1,
  output logic space_code_bit0,
  // Data bus
  input wire logic [cebi_pkg::DATA_W-1:0] data_bus_in,
  output logic [cebi_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  // Transfer control
  output logic addr_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic read_write,
  input wire logic xfer_ack_n,
  // Arbitration
  input wire logic bus_req_n,
  output logic bus_grant_n,
  // Interrupts and system control
  input wire logic irq_level_bit2_n,
  input wire logic irq_level_bit1_n,
  input wire logic irq_level_bit0_n,
  input wire logic auto_vector_n,
  input wire logic bus_fault_n,
  input wire logic ext_reset_n,
  input wire logic halt_n,
  input wire logic mode_16bit
);
  import cebi_pkg::*;

  // ****************************************
  // Register port
  // ****************************************
  logic pend_r;
  logic hwrite_q_r;
  logic [OFS_W-1:0] hofs_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0] ctrl_r;
  logic [2:0] mask_r;
  logic cmd_pend_r;
  logic done_r;
  logic fault_r;
  logic auto_vector_n_r;
  logic [LVL_W-1:0] lvl_r;
  logic [LVL_W-1:0] svc_lvl_r;
  cebi_state_t state_r;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic wr_en;
  logic busy;
  logic irq_pend;
  logic start_go;
  logic ack_seen;
  logic fault_seen;
  logic iack_cyc;

  assign wr_en = pend_r && hwrite_q_r;
  assign busy = cmd_pend_r || !(state_r == S_IDLE || state_r == S_GRANT);
  assign iack_cyc = ctrl_r[CTL_IACK];
  // Level seven passes whatever the mask holds
  assign irq_pend = (lvl_r == LVL_NMI) || (lvl_r > mask_r);
  assign start_go = (state_r == S_IDLE) && ext_reset_n && bus_req_n && cmd_pend_r
                    && halt_n;
  assign fault_seen = (state_r == S_WAIT) && !bus_fault_n;
  assign ack_seen = (state_r == S_WAIT) && bus_fault_n
                    && (!xfer_ack_n || (iack_cyc && !auto_vector_n));

  // One wait state per transfer so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= 1'b0;
      hwrite_q_r <= 1'b0;
      hofs_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else if (pend_r)
    begin
      pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= hwrite_q_r ? 32'h0000_0000 : rd_mux;
    end
    else if (hsel && htrans[1] && hready)
    begin
      pend_r <= 1'b1;
      hwrite_q_r <= hwrite;
      hofs_r <= haddr[OFS_W-1:0];
      hreadyout <= 1'b0;
    end
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STS_BUSY] = busy;
    status_word[STS_DONE] = done_r;
    status_word[STS_FAULT] = fault_r;
    status_word[STS_AUTO_VECTOR_N] = auto_vector_n_r;
    status_word[STS_HALTED] = !halt_n;
    status_word[STS_GRANTED] = state_r == S_GRANT;
    status_word[STS_IRQ] = irq_pend;
    status_word[STS_LVL_LSB +: LVL_W] = lvl_r;
    status_word[STS_MODE16] = mode_16bit;
    rd_mux = 32'h0000_0000;
    unique case (hofs_r)
      OFS_ADDR: rd_mux = {8'h00, addr_r};
      OFS_WDATA: rd_mux = {16'h0000, wdata_r};
      OFS_CTRL: rd_mux = {24'h000000, ctrl_r[7:1], busy};
      OFS_STATUS: rd_mux = status_word;
      OFS_MASK: rd_mux = {29'h0000_0000, mask_r};
      OFS_RDATA: rd_mux = {16'h0000, rdata_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 24'h000000;
      wdata_r <= 16'h0000;
      ctrl_r <= 8'h00;
      mask_r <= MASK_RST;
    end
    else if (wr_en)
    begin
      if (hofs_r == OFS_ADDR && !busy)
        addr_r <= hwdata[ADDR_W-1:0];
      if (hofs_r == OFS_WDATA && !busy)
        wdata_r <= hwdata[DATA_W-1:0];
      if (hofs_r == OFS_CTRL && !busy)
        ctrl_r <= hwdata[7:0];
      if (hofs_r == OFS_MASK)
        mask_r <= hwdata[2:0];
    end
  end

  // Start is dropped while a cycle runs; software polls busy first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd_pend_r <= 1'b0;
    else if (!ext_reset_n || start_go)
      cmd_pend_r <= 1'b0;
    else if (wr_en && hofs_r == OFS_CTRL && !busy && hwdata[CTL_START])
      cmd_pend_r <= 1'b1;
  end

  // Write-one-to-clear flags; a new event in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      auto_vector_n_r <= 1'b0;
    end
    else
    begin
      if (ack_seen || fault_seen)
        done_r <= 1'b1;
      else if (wr_en && hofs_r == OFS_STATUS && hwdata[STS_DONE])
        done_r <= 1'b0;
      if (fault_seen)
        fault_r <= 1'b1;
      else if (wr_en && hofs_r == OFS_STATUS && hwdata[STS_FAULT])
        fault_r <= 1'b0;
      if (ack_seen && iack_cyc && !auto_vector_n)
        auto_vector_n_r <= 1'b1;
      else if (wr_en && hofs_r == OFS_STATUS && hwdata[STS_AUTO_VECTOR_N])
        auto_vector_n_r <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt level and read data capture
  // ****************************************
  // Inputs are active low; all high means no request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl_r <= 3'h0;
    else
      lvl_r <= ~{irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_r <= 16'h0000;
    else if (ack_seen && iack_cyc && !auto_vector_n)
      rdata_r <= {8'h00, AUTOVEC_BASE + {5'h00, svc_lvl_r}};
    else if (ack_seen && ctrl_r[CTL_READ] && iack_cyc)
      rdata_r <= {8'h00, data_bus_in[7:0]};
    else if (ack_seen && ctrl_r[CTL_READ] && !mode_16bit)
      rdata_r <= {8'h00, data_bus_in[7:0]};
    else if (ack_seen && ctrl_r[CTL_READ])
      rdata_r <= data_bus_in;
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  // Flops hold through a stopped clock; nothing here needs refresh
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= S_IDLE;
    else if (!ext_reset_n)
      state_r <= S_IDLE;
    else
    begin
      unique case (state_r)
        S_IDLE:
          if (!bus_req_n)
            state_r <= S_GRANT;
          else if (start_go)
            state_r <= S_ADDR;
        S_ADDR: state_r <= S_WAIT;
        S_WAIT:
          if (ack_seen || fault_seen)
            state_r <= S_END;
        S_END:
          if (xfer_ack_n && bus_fault_n && auto_vector_n)
            state_r <= S_IDLE;
        S_GRANT:
          if (bus_req_n)
            state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Grant answers at once; bus is only let go from idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bus_grant_n <= 1'b1;
    else
      bus_grant_n <= bus_req_n;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_bus <= 24'h000000;
      svc_lvl_r <= 3'h0;
      read_write <= 1'b1;
      data_bus_out <= 16'h0000;
      space_code_bit2 <= FC_RST[2];
      space_code_bit1 <= FC_RST[1];
      space_code_bit0 <= FC_RST[0];
    end
    else if (start_go && iack_cyc)
    begin
      addr_bus <= {IACK_HIGH, lvl_r, 1'b1};
      svc_lvl_r <= lvl_r;
      read_write <= 1'b1;
      {space_code_bit2, space_code_bit1, space_code_bit0} <= FC_IACK;
    end
    else if (start_go)
    begin
      addr_bus <= addr_r;
      read_write <= ctrl_r[CTL_READ];
      data_bus_out <= mode_16bit ? wdata_r : {8'h00, wdata_r[7:0]};
      {space_code_bit2, space_code_bit1, space_code_bit0} <=
        ctrl_r[CTL_FC_LSB +: 3];
    end
  end

  // Pins float under external reset and while another master owns the bus; data pins drive only in write cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_bus_oe <= 1'b0;
      data_bus_oe <= 1'b0;
    end
    else if (!ext_reset_n || state_r == S_GRANT || (state_r == S_IDLE && !bus_req_n))
    begin
      addr_bus_oe <= 1'b0;
      data_bus_oe <= 1'b0;
    end
    else if (start_go)
    begin
      addr_bus_oe <= 1'b1;
      data_bus_oe <= !ctrl_r[CTL_READ] && !iack_cyc;
    end
    else if (state_r == S_END && xfer_ack_n && bus_fault_n && auto_vector_n)
      data_bus_oe <= 1'b0;
  end

  // Strobes follow the address by one cycle so it is settled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
    end
    else if (!ext_reset_n || ack_seen || fault_seen)
    begin
      addr_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
    end
    else if (state_r == S_ADDR)
    begin
      addr_strobe_n <= 1'b0;
      // Narrow mode carries every byte on the lower lane
      upper_byte_strobe_n <= !(mode_16bit && ctrl_r[CTL_UPPER] && !iack_cyc);
      lower_byte_strobe_n <= !(ctrl_r[CTL_LOWER] || iack_cyc
                               || (!mode_16bit && ctrl_r[CTL_UPPER]));
    end
  end

endmodule
`default_nettype wire

// [inc/cebi_pkg.sv]
// Constants, register map and state codes of the external bus interface.
// Assumes a single clock and an AHB-Lite master with word accesses only.
//
// Notes on behaviour
// - Drive 24-bit address on every non-acknowledge cycle
// - Acknowledge cycle: level on addr 3..1, rest high
// - Mode pin fixes 8/16-bit width; data three-stated
// - Address strobe only while address is valid
// - Read/write line marks direction of each transfer
// - Separate upper and lower byte strobes
// - Grant at once, release bus at cycle end
// - Three encoded level inputs give seven levels
// - Level seven highest and never masked
// - Autovector input derives vector from level
// - Bus fault input ends access as error
// - Obey external reset and halt inputs
// - Space code outputs valid with address strobe
// - Static state kept while clock stopped
package cebi_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int LVL_W = 3;
  localparam int OFS_W = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTL_START = 0;
  localparam int CTL_READ = 1;
  localparam int CTL_UPPER = 2;
  localparam int CTL_LOWER = 3;
  localparam int CTL_FC_LSB = 4;
  localparam int CTL_IACK = 7;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_FAULT = 2;
  localparam int STS_AUTO_VECTOR_N = 3;
  localparam int STS_HALTED = 4;
  localparam int STS_GRANTED = 5;
  localparam int STS_IRQ = 6;
  localparam int STS_LVL_LSB = 8;
  localparam int STS_MODE16 = 11;

  // ****************************************
  // Reset values and fixed codes
  // ****************************************
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [2:0] FC_RST = 3'h5;
  localparam logic [2:0] FC_IACK = 3'h7;
  localparam logic [2:0] LVL_NMI = 3'h7;
  localparam logic [19:0] IACK_HIGH = 20'hFFFFF;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;

  typedef enum logic [5:0]
  {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_WAIT = 6'b000100,
    S_END = 6'b001000,
    S_GRANT = 6'b010000,
    S_SPARE = 6'b100000
  } cebi_state_t;

endpackage

// [bench/cebi_properties.sv]
// Bus-side assertions for the external bus interface.
// Assumes one clock; bound to cebi_top by the bench.
`timescale 1ns/1ps
`default_nettype none
module cebi_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus pins
  input wire logic [cebi_pkg::ADDR_W-1:0] addr_bus,
  input wire logic addr_bus_oe,
  input wire logic space_code_bit2,
  input wire logic space_code_bit1,
  input wire logic space_code_bit0,
  input wire logic addr_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic xfer_ack_n,
  input wire logic bus_fault_n,
  input wire logic auto_vector_n,
  input wire logic bus_req_n,
  input wire logic bus_grant_n,
  input wire logic ext_reset_n,
  input wire logic mode_16bit
);
  import cebi_pkg::*;
  wire logic [2:0] fc = {space_code_bit2, space_code_bit1, space_code_bit0};
  wire logic lane_n = upper_byte_strobe_n && lower_byte_strobe_n;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_lane_in_as: assert property (!lane_n |-> !addr_strobe_n)
    else $error("lane strobe without as");
  a_as_drives: assert property (!addr_strobe_n |-> addr_bus_oe)
    else $error("as while bus released");
  a_iack_addr: assert property (!addr_strobe_n && fc == FC_IACK |->
    addr_bus[23:4] == IACK_HIGH && addr_bus[0]) else $error("bad iack address");
  a_code_hold: assert property (!addr_strobe_n ##1 !addr_strobe_n |->
    $stable({fc, addr_bus})) else $error("code moved under as");
  a_wait_ack: assert property (!addr_strobe_n && xfer_ack_n && bus_fault_n &&
    auto_vector_n && ext_reset_n |=> !addr_strobe_n) else $error("cycle ended early");
  a_ack_ends: assert property (!addr_strobe_n && !xfer_ack_n |=>
    addr_strobe_n && lane_n) else $error("strobes kept after ack");
  a_no_restart: assert property (addr_strobe_n && !xfer_ack_n |=> addr_strobe_n)
    else $error("restart before ack release");
  a_grant_follow: assert property (!bus_req_n |=> !bus_grant_n)
    else $error("grant late");
  a_lane_8bit: assert property (!mode_16bit |-> upper_byte_strobe_n)
    else $error("upper lane in 8-bit mode");
  c_ack: cover property (!addr_strobe_n && !xfer_ack_n);
  c_fault: cover property (!addr_strobe_n && !bus_fault_n);
  c_auto_vector_n: cover property (!addr_strobe_n && !auto_vector_n);
endmodule
`default_nettype wire

// [bench/cebi_mem.sv]
// Memory and peripheral model on the strobe bus.
// Assumes strobes change on hclk edges only.
`timescale 1ns/1ps
`default_nettype none
module cebi_mem (
  // From the device
  input wire logic hclk,
  input wire logic [23:0] addr_bus,
  input wire logic [15:0] data_bus_out,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic read_write,
  // Scenario controls
  input var int dly,
  input wire logic fault_en,
  input wire logic auto_vector_n_en,
  // Answers
  output logic xfer_ack_n,
  output logic bus_fault_n,
  output logic auto_vector_n,
  output logic [15:0] data_bus_in
);
  logic [15:0] mem [16];
  int cnt;
  wire logic sel = !(upper_byte_strobe_n && lower_byte_strobe_n);
  wire logic [3:0] ix = addr_bus[4:1];
  // ****
  // Answer logic
  // ****
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h1000 + 16'(i);
    xfer_ack_n = 1;
    bus_fault_n = 1;
    auto_vector_n = 1;
    data_bus_in = 16'h0;
  end
  always @(posedge hclk)
  begin
    // Undriven data keeps moving so stale values never pass
    data_bus_in <= ~data_bus_in;
    if (!sel)
    begin
      cnt <= 0;
      xfer_ack_n <= 1;
      bus_fault_n <= 1;
      auto_vector_n <= 1;
    end
    else if (cnt < dly)
      cnt <= cnt + 1;
    else if (fault_en)
      bus_fault_n <= 0;
    else if (auto_vector_n_en)
      auto_vector_n <= 0;
    else
    begin
      xfer_ack_n <= 0;
      if (read_write)
        data_bus_in <= mem[ix];
      if (!read_write && !upper_byte_strobe_n)
        mem[ix][15:8] <= data_bus_out[15:8];
      if (!read_write && !lower_byte_strobe_n)
        mem[ix][7:0] <= data_bus_out[7:0];
    end
  end
endmodule
`default_nettype wire

// [bench/cebi_top_tb.sv]
// Self-checking bench for the external bus interface.
// Assumes the memory model answers every strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module cebi_top_tb;
  import cebi_pkg::*;
  typedef struct {logic [23:0] a; logic [15:0] d; logic [1:0] ln; logic [2:0] fc;
    logic [15:0] x;} cebi_row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, st;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, lvl_n = 3'h7;
  logic hreadyout, hresp, addr_bus_oe, data_bus_oe, addr_strobe_n, read_write, bus_grant_n;
  logic upper_byte_strobe_n, lower_byte_strobe_n, xfer_ack_n, auto_vector_n, bus_fault_n;
  logic space_code_bit2, space_code_bit1, space_code_bit0;
  logic [23:0] addr_bus;
  logic [15:0] data_bus_in, data_bus_out;
  logic bus_req_n = 1, ext_reset_n = 1, halt_n = 1, mode_16bit = 1, fault_en = 0, auto_vector_n_en = 0;
  logic clk_run = 1;
  wire logic hready = hreadyout;
  wire logic irq_level_bit2_n = lvl_n[2];
  wire logic irq_level_bit1_n = lvl_n[1];
  wire logic irq_level_bit0_n = lvl_n[0];
  int dly = 0, fail_count = 0, n_checks = 0, cyc = 0;
  // Write row, then read back: lanes not strobed keep old bytes
  cebi_row_t rows[3] = '{'{24'hFFFFFE, 16'hBEEF, 2'h3, 3'h5, 16'hBEEF},
    '{24'h000002, 16'h1234, 2'h2, 3'h1, 16'h1201},
    '{24'h800004, 16'h5678, 2'h1, 3'h2, 16'h1078}};
  cebi_top dut_u (.*);
  cebi_mem mem_u (.*);
  // Gate lets one scenario stop the clock with state held
  always #2.5 hclk = clk_run ? ~hclk : hclk;
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (!hreadyout);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask
  // Polls until done; only the cycle ceiling ends a hang
  task automatic wt;
    do
    begin
      ahb(0, OFS_STATUS, 0);
      st = r & 32'hFFE;
    end
    while (!st[STS_DONE]);
    ahb(1, OFS_STATUS, 32'hE);
  endtask
  task automatic go(input logic [23:0] a, input logic [15:0] d, input logic [7:0] c);
    ahb(1, OFS_ADDR, {8'h0, a});
    ahb(1, OFS_WDATA, {16'h0, d});
    ahb(1, OFS_CTRL, {24'h0, c});
    wt;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    chk({addr_bus_oe, addr_strobe_n, space_code_bit2, space_code_bit1, space_code_bit0}, 5'hD);
    ahb(0, OFS_MASK, 0);
    chk(r, {29'h0, MASK_RST});
    ahb(1, 8'h20, 32'hFFFF);
    ahb(0, 8'h20, 0);
    chk(r, 0);
    foreach (rows[i])
    begin
      dly <= i * 3;
      go(rows[i].a, rows[i].d, {1'b0, rows[i].fc, rows[i].ln[0], rows[i].ln[1], 2'h1});
      chk({read_write, space_code_bit2, space_code_bit1, space_code_bit0, addr_bus},
        {1'b0, rows[i].fc, rows[i].a});
      go(rows[i].a, 0, {1'b0, rows[i].fc, 4'hF});
      ahb(0, OFS_RDATA, 0);
      chk(r, {16'h0, rows[i].x});
    end
    lvl_n <= 3'h2;
    auto_vector_n_en <= 1;
    go(0, 0, 8'h8B);
    chk(st, 32'hD0A);
    chk({addr_bus, space_code_bit2, space_code_bit1, space_code_bit0},
      {IACK_HIGH, 3'h5, 1'b1, FC_IACK});
    ahb(0, OFS_RDATA, 0);
    chk(r, {24'h0, AUTOVEC_BASE + 8'h5});
    lvl_n <= 3'h0;
    auto_vector_n_en <= 0;
    go(0, 0, 8'h8B);
    chk(st, 32'hF42);
    ahb(0, OFS_RDATA, 0);
    chk(r, 32'hEF);
    lvl_n <= 3'h7;
    fault_en <= 1;
    go(24'h10, 0, 8'h5D);
    chk(st, 32'h806);
    fault_en <= 0;
    dly <= 8;
    ahb(1, OFS_CTRL, 32'h5D);
    while (addr_strobe_n) @(posedge hclk);
    bus_req_n <= 0;
    repeat (2) @(posedge hclk);
    chk({bus_grant_n, addr_bus_oe}, 2'h1);
    wt;
    ahb(0, OFS_STATUS, 0);
    chk({r[STS_GRANTED], addr_bus_oe}, 2'h2);
    ahb(1, OFS_CTRL, 32'h5D);
    repeat (10) @(posedge hclk);
    chk(addr_strobe_n, 1);
    bus_req_n <= 1;
    wt;
    chk(bus_grant_n, 1);
    halt_n <= 0;
    ahb(1, OFS_CTRL, 32'h5D);
    repeat (10) @(posedge hclk);
    ahb(0, OFS_STATUS, 0);
    chk({r[STS_HALTED], r[STS_DONE], addr_strobe_n}, 3'h5);
    halt_n <= 1;
    wt;
    // External reset in mid-cycle drops the strobes and the pins
    ahb(1, OFS_CTRL, 32'h5D);
    while (addr_strobe_n) @(posedge hclk);
    ext_reset_n <= 0;
    repeat (2) @(posedge hclk);
    chk({addr_strobe_n, addr_bus_oe, data_bus_oe}, 3'h4);
    ext_reset_n <= 1;
    ahb(0, OFS_STATUS, 0);
    chk(r[STS_DONE:STS_BUSY], 2'h0);
    dly <= 0;
    mode_16bit <= 0;
    go(24'h000006, 16'h00AB, 8'h15);
    mode_16bit <= 1;
    go(24'h000006, 0, 8'h1F);
    ahb(0, OFS_RDATA, 0);
    chk(r, 32'h10AB);
    lvl_n <= 3'h2;
    ahb(1, OFS_MASK, 32'h4);
    ahb(0, OFS_STATUS, 0);
    chk({r[STS_IRQ], r[STS_LVL_LSB +: 3]}, 4'hD);
    clk_run = 0;
    #200;
    clk_run = 1;
    ahb(0, OFS_MASK, 0);
    chk(r, 32'h4);
    ahb(0, OFS_ADDR, 0);
    chk(r, 32'h6);
    print_verdict;
  end
endmodule
bind cebi_top cebi_chk chk_u (.*);
`default_nettype wire
